/* dcc_core_ctrl.sv */
// DSP core control, safeload sequencer and modulo data RAM addressing
// What this block does
// - Bit 14 resets high, enables third and fourth serial outputs; 0 off.
// - Bit 13 sets when slew RAM mute completes; a read clears it.
// - While bit 12 is set all target RAM locations act as zero.
// - Bit 9 low holds accumulators and serial outputs at zero; resets low.
// - Bit 8 high forces the multiplier input to zero.
// - Bit 7 zeroes all data memory then clears itself.
// - Bit 6 high forces all DSP input channels to zero.
// - Bit 5 starts safeload into target RAM, self-clearing when done.
// - Bit 4 starts safeload into parameter RAM, self-clearing when done.
// - Only pairs written since the last safeload are copied.
// - Safeload address zero is the first location of the destination RAM.
// - Program length code 00 gives 2560, 01 gives 1280, 10 gives 640.
// - Modulo pointer advances at the end of every sample period.
// - Modulo size counts 512-word units, resets to full 20480 words.
// - Modulo region starts at zero; addresses above are not offset.
`timescale 1ns/100ps
module dcc_core_ctrl
  import dcc_pkg::*;
#(
  parameter int SL_DATA_W = 32
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  // Control port register access
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  output logic      [31:0]        reg_rdata_o,
  // Core sequencer events
  input  wire logic               sample_end_i,
  input  wire logic               slew_mute_done_i,
  // Data path controls
  output logic                    serial_out_third_en_o,
  output logic                    serial_out_fourth_en_o,
  output logic                    target_zero_o,
  output logic                    clear_regs_o,
  output logic                    mult_zero_o,
  output logic                    input_zero_o,
  output logic      [11:0]        prog_steps_o,
  // Data memory zeroing and modulo address translation
  output dcc_dmem_clr_t           dmem_clr_o,
  input  wire logic [DMEM_AW-1:0] core_addr_i,
  output logic      [DMEM_AW-1:0] dmem_addr_o,
  // Safeload writes toward target or parameter RAM
  output dcc_sl_wr_t              sl_wr_o
);

  logic [15:0]          ctrl;
  logic [15:0]          mod_size;
  logic [15:0]          sl_addr [SL_PAIRS];
  logic [31:0]          sl_data [SL_PAIRS];
  logic [SL_PAIRS-1:0]  sl_written;
  logic [DMEM_AW-1:0]   mod_ptr;
  logic [DMEM_AW-1:0]   clr_cnt;
  logic                 clr_done;
  dcc_sl_state_t        sl_state;
  logic [2:0]           sl_idx;
  logic                 sl_to_param;
  logic                 sl_done;
  logic                 wr_ctrl;
  logic                 rd_ctrl;
  logic [DMEM_AW-1:0]   mod_len;

  // Size of modulo region in words; 0 or oversize means the whole memory
  function automatic logic [DMEM_AW-1:0] mod_words(input logic [15:0] blk);
    logic [15:0] b;
    b = (blk == 16'h0000 || blk > MOD_BLOCKS_MAX) ? MOD_BLOCKS_MAX : blk;
    return DMEM_AW'(b * 16'(MOD_UNIT_WORDS));
  endfunction : mod_words

  // Wrap a pointer-offset address back inside the modulo region
  function automatic logic [DMEM_AW-1:0] mod_add(
    input logic [DMEM_AW-1:0] a,
    input logic [DMEM_AW-1:0] b,
    input logic [DMEM_AW-1:0] len
  );
    logic [DMEM_AW:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    return s[DMEM_AW-1:0];
  endfunction : mod_add

  assign wr_ctrl = reg_wr_i && (reg_addr_i == CORE_CTRL_ADDR);
  assign rd_ctrl = reg_rd_i && (reg_addr_i == CORE_CTRL_ADDR);
  assign mod_len = mod_words(mod_size);

  // Control register; hardware clears start bits, mute flag set wins
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= CORE_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl[BIT_SO_EN]     <= reg_wdata_i[BIT_SO_EN];
        ctrl[BIT_TGT_ZERO]  <= reg_wdata_i[BIT_TGT_ZERO];
        ctrl[BIT_RUN]       <= reg_wdata_i[BIT_RUN];
        ctrl[BIT_MULT_ZERO] <= reg_wdata_i[BIT_MULT_ZERO];
        ctrl[BIT_IN_ZERO]   <= reg_wdata_i[BIT_IN_ZERO];
        ctrl[PLEN_LSB+1:PLEN_LSB] <= reg_wdata_i[PLEN_LSB+1:PLEN_LSB];
      end
      // A write of 1 starts an operation; its completion clears it
      if (wr_ctrl && reg_wdata_i[BIT_DMEM_INIT]) begin
        ctrl[BIT_DMEM_INIT] <= 1'b1;
      end else if (clr_done) begin
        ctrl[BIT_DMEM_INIT] <= 1'b0;
      end
      if (wr_ctrl && reg_wdata_i[BIT_SL_TARGET]) begin
        ctrl[BIT_SL_TARGET] <= 1'b1;
      end else if (sl_done && !sl_to_param) begin
        ctrl[BIT_SL_TARGET] <= 1'b0;
      end
      if (wr_ctrl && reg_wdata_i[BIT_SL_PARAM]) begin
        ctrl[BIT_SL_PARAM] <= 1'b1;
      end else if (sl_done && sl_to_param) begin
        ctrl[BIT_SL_PARAM] <= 1'b0;
      end
      if (slew_mute_done_i) begin
        ctrl[BIT_SLEW_MUTED] <= 1'b1;
      end else if (rd_ctrl) begin
        ctrl[BIT_SLEW_MUTED] <= 1'b0;
      end
    end
  end

  // Modulo size register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mod_size <= MOD_SIZE_RST;
    end else if (reg_wr_i && reg_addr_i == MOD_SIZE_ADDR) begin
      mod_size <= reg_wdata_i[15:0];
    end
  end

  // Safeload pairs and their written markers; a fresh write beats a clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sl_written <= '0;
      for (int i = 0; i < SL_PAIRS; i++) begin
        sl_addr[i] <= 16'h0000;
        sl_data[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < SL_PAIRS; i++) begin
        if (sl_state == DCC_SL_COPY && sl_idx == 3'(i)) begin
          sl_written[i] <= 1'b0;
        end
        if (reg_wr_i && reg_addr_i == SL_ADDR_BASE + 8'(i)) begin
          sl_addr[i]    <= reg_wdata_i[15:0];
          sl_written[i] <= 1'b1;
        end
        if (reg_wr_i && reg_addr_i == SL_DATA_BASE + 8'(i)) begin
          sl_data[i]    <= reg_wdata_i;
          sl_written[i] <= 1'b1;
        end
      end
    end
  end

  // Safeload sequencer: waits for a sample boundary, then copies pairs
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sl_state    <= DCC_SL_IDLE;
      sl_idx      <= 3'h0;
      sl_to_param <= 1'b0;
      sl_done     <= 1'b0;
    end else begin
      sl_done <= 1'b0;
      case (sl_state)
        DCC_SL_IDLE: begin
          // Target transfer is served first when both are requested
          if (ctrl[BIT_SL_TARGET] && !sl_done) begin
            sl_to_param <= 1'b0;
            sl_state    <= DCC_SL_WAIT;
          end else if (ctrl[BIT_SL_PARAM] && !sl_done) begin
            sl_to_param <= 1'b1;
            sl_state    <= DCC_SL_WAIT;
          end
        end
        DCC_SL_WAIT: begin
          if (sample_end_i) begin
            sl_idx   <= 3'h0;
            sl_state <= DCC_SL_COPY;
          end
        end
        DCC_SL_COPY: begin
          if (sl_idx == 3'(SL_PAIRS - 1)) begin
            sl_done  <= 1'b1;
            sl_state <= DCC_SL_IDLE;
          end else begin
            sl_idx <= sl_idx + 3'h1;
          end
        end
        default: sl_state <= DCC_SL_IDLE;
      endcase
    end
  end

  // Safeload write out; address passes unchanged, so 0 is the first word
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sl_wr_o <= '0;
    end else begin
      sl_wr_o.we       <= (sl_state == DCC_SL_COPY) &&
                          sl_written[sl_idx];
      sl_wr_o.to_param <= sl_to_param;
      sl_wr_o.addr     <= sl_addr[sl_idx];
      sl_wr_o.data     <= SL_DATA_W'(sl_data[sl_idx]);
    end
  end

  // Data memory zeroing sweep, one word per cycle
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_cnt    <= '0;
      clr_done   <= 1'b0;
      dmem_clr_o <= '0;
    end else begin
      clr_done      <= 1'b0;
      dmem_clr_o.we <= 1'b0;
      if (ctrl[BIT_DMEM_INIT] && !clr_done) begin
        dmem_clr_o.we   <= 1'b1;
        dmem_clr_o.addr <= clr_cnt;
        if (clr_cnt == DMEM_AW'(DMEM_WORDS - 1)) begin
          clr_cnt  <= '0;
          clr_done <= 1'b1;
        end else begin
          clr_cnt <= clr_cnt + 1'b1;
        end
      end
    end
  end

  // Modulo pointer steps once per sample, wrapping at the region size
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mod_ptr <= '0;
    end else if (mod_ptr >= mod_len) begin
      mod_ptr <= '0;
    end else if (sample_end_i) begin
      mod_ptr <= mod_add(mod_ptr, DMEM_AW'(1), mod_len);
    end
  end

  // Address translation; the non-modulo region bypasses the pointer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dmem_addr_o <= '0;
    end else if (core_addr_i < mod_len) begin
      dmem_addr_o <= mod_add(core_addr_i, mod_ptr, mod_len);
    end else begin
      dmem_addr_o <= core_addr_i;
    end
  end

  // Data path controls straight from the control register
  assign serial_out_third_en_o  = ctrl[BIT_SO_EN];
  assign serial_out_fourth_en_o = ctrl[BIT_SO_EN];
  assign target_zero_o          = ctrl[BIT_TGT_ZERO];
  assign clear_regs_o           = !ctrl[BIT_RUN];
  assign mult_zero_o            = ctrl[BIT_MULT_ZERO];
  assign input_zero_o           = ctrl[BIT_IN_ZERO];

  // Program length; the reserved code 11 falls back to the full program
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_steps_o <= PLEN_FULL_STEPS;
    end else begin
      case (dcc_plen_t'(ctrl[PLEN_LSB+1:PLEN_LSB]))
        DCC_PLEN_HALF:    prog_steps_o <= PLEN_HALF_STEPS;
        DCC_PLEN_QUARTER: prog_steps_o <= PLEN_QUARTER_STEPS;
        default:          prog_steps_o <= PLEN_FULL_STEPS;
      endcase
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads return 0
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_addr_i == CORE_CTRL_ADDR) begin
        reg_rdata_o[15:0] <= ctrl & 16'h73f3;
      end else if (reg_addr_i == MOD_SIZE_ADDR) begin
        reg_rdata_o[15:0] <= mod_size;
      end
      for (int i = 0; i < SL_PAIRS; i++) begin
        if (reg_addr_i == SL_ADDR_BASE + 8'(i)) begin
          reg_rdata_o[15:0] <= sl_addr[i];
        end
        if (reg_addr_i == SL_DATA_BASE + 8'(i)) begin
          reg_rdata_o <= sl_data[i];
        end
      end
    end
  end

endmodule : dcc_core_ctrl

/* dcc_pkg.sv */
// Constants and types shared by the DSP core control block
package dcc_pkg;

  // Register indices on the control port (word addresses)
  localparam logic [7:0] CORE_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] MOD_SIZE_ADDR   = 8'h01;
  localparam logic [7:0] SL_ADDR_BASE    = 8'h10;
  localparam logic [7:0] SL_DATA_BASE    = 8'h18;
  localparam int         SL_PAIRS        = 5;

  // Core control field positions
  localparam int BIT_SO_EN      = 14;
  localparam int BIT_SLEW_MUTED = 13;
  localparam int BIT_TGT_ZERO   = 12;
  localparam int BIT_RUN        = 9;
  localparam int BIT_MULT_ZERO  = 8;
  localparam int BIT_DMEM_INIT  = 7;
  localparam int BIT_IN_ZERO    = 6;
  localparam int BIT_SL_TARGET  = 5;
  localparam int BIT_SL_PARAM   = 4;
  localparam int PLEN_LSB       = 0;

  // Values after reset
  localparam logic [15:0] CORE_CTRL_RST = 16'h4000;
  localparam logic [15:0] MOD_SIZE_RST  = 16'h0028;

  // Data memory geometry
  localparam int          MOD_UNIT_WORDS  = 512;
  localparam int          DMEM_WORDS      = 20480;
  localparam int          DMEM_AW         = 15;
  localparam logic [15:0] MOD_BLOCKS_MAX  = 16'h0028;

  // Program length codes and their instruction counts
  typedef enum logic [1:0] {
    DCC_PLEN_FULL    = 2'b00,
    DCC_PLEN_HALF    = 2'b01,
    DCC_PLEN_QUARTER = 2'b10
  } dcc_plen_t;
  localparam logic [11:0] PLEN_FULL_STEPS    = 12'ha00;
  localparam logic [11:0] PLEN_HALF_STEPS    = 12'h500;
  localparam logic [11:0] PLEN_QUARTER_STEPS = 12'h280;

  // Safeload sequencer states
  typedef enum logic [1:0] {
    DCC_SL_IDLE = 2'b00,
    DCC_SL_WAIT = 2'b01,
    DCC_SL_COPY = 2'b10
  } dcc_sl_state_t;

  // One safeload write toward the target or parameter RAM
  typedef struct packed {
    logic        we;
    logic        to_param;
    logic [15:0] addr;
    logic [31:0] data;
  } dcc_sl_wr_t;

  // Zeroing write into data memory during initialisation
  typedef struct packed {
    logic               we;
    logic [DMEM_AW-1:0] addr;
  } dcc_dmem_clr_t;

endpackage : dcc_pkg

/* dcc_core_ctrl_chk.sv */
// Assertion checker for the DSP core control block
`timescale 1ns/100ps
module dcc_core_ctrl_chk
  import dcc_pkg::*;
(
  // Clock, reset and register port
  input wire logic          ref_clk_i,
  input wire logic          reset_n_i,
  input wire logic          reg_wr_i,
  input wire logic          reg_rd_i,
  input wire logic [7:0]    reg_addr_i,
  input wire logic [31:0]   reg_wdata_i,
  input wire logic [31:0]   reg_rdata_o,
  // Events and controls
  input wire logic          sample_end_i,
  input wire logic          slew_mute_done_i,
  input wire logic          serial_out_third_en_o,
  input wire logic          target_zero_o,
  input wire logic          clear_regs_o,
  input wire logic          mult_zero_o,
  input wire logic          input_zero_o,
  input wire logic [11:0]   prog_steps_o,
  input wire dcc_dmem_clr_t dmem_clr_o,
  input wire dcc_sl_wr_t    sl_wr_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = reg_wr_i && (reg_addr_i == CORE_CTRL_ADDR);
  assign ctl_rd = reg_rd_i && (reg_addr_i == CORE_CTRL_ADDR);
  sequence s_mute_rd;
    slew_mute_done_i ##1 ctl_rd;
  endsequence
  sequence s_init_wr;
    ctl_wr && reg_wdata_i[BIT_DMEM_INIT];
  endsequence
  property p_so_en;
    ctl_wr |=> serial_out_third_en_o == $past(reg_wdata_i[BIT_SO_EN]);
  endproperty
  property p_tz;
    ctl_wr |=> target_zero_o == $past(reg_wdata_i[BIT_TGT_ZERO]);
  endproperty
  property p_clr;
    ctl_wr |=> clear_regs_o == !$past(reg_wdata_i[BIT_RUN]);
  endproperty
  property p_mz;
    ctl_wr |=> mult_zero_o == $past(reg_wdata_i[BIT_MULT_ZERO]);
  endproperty
  property p_iz;
    ctl_wr |=> input_zero_o == $past(reg_wdata_i[BIT_IN_ZERO]);
  endproperty
  property p_plen;
    ctl_wr |-> ##2 prog_steps_o ==
      (($past(reg_wdata_i[1:0], 2) == 2'b01) ? PLEN_HALF_STEPS :
       ($past(reg_wdata_i[1:0], 2) == 2'b10) ? PLEN_QUARTER_STEPS :
       PLEN_FULL_STEPS);
  endproperty
  property p_mute;
    s_mute_rd |=> reg_rdata_o[BIT_SLEW_MUTED];
  endproperty
  property p_dmem_start;
    s_init_wr |-> ##2 (dmem_clr_o.we && dmem_clr_o.addr == '0);
  endproperty
  property p_dmem_step;
    dmem_clr_o.we && $past(dmem_clr_o.we) |->
      dmem_clr_o.addr == $past(dmem_clr_o.addr) + 1'b1;
  endproperty
  // Copies may only follow a sample boundary, never run mid-sample
  property p_sl_gap;
    sl_wr_o.we |-> $past(sample_end_i, 2) || $past(sample_end_i, 3) ||
      $past(sample_end_i, 4) || $past(sample_end_i, 5) ||
      $past(sample_end_i, 6);
  endproperty
  a_so_en: assert property (p_so_en) else $error("output enable");
  a_tz: assert property (p_tz) else $error("target zero");
  a_clr: assert property (p_clr) else $error("clear regs");
  a_mz: assert property (p_mz) else $error("mult zero");
  a_iz: assert property (p_iz) else $error("input zero");
  a_plen: assert property (p_plen) else $error("prog steps");
  a_mute: assert property (p_mute) else $error("mute flag");
  a_dmem_start: assert property (p_dmem_start) else $error("init");
  a_dmem_step: assert property (p_dmem_step) else $error("init step");
  a_sl_gap: assert property (p_sl_gap) else $error("safeload gap");
endmodule : dcc_core_ctrl_chk

bind dcc_core_ctrl dcc_core_ctrl_chk u_dcc_core_ctrl_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .sample_end_i(sample_end_i),
  .slew_mute_done_i(slew_mute_done_i),
  .serial_out_third_en_o(serial_out_third_en_o),
  .target_zero_o(target_zero_o), .clear_regs_o(clear_regs_o),
  .mult_zero_o(mult_zero_o), .input_zero_o(input_zero_o),
  .prog_steps_o(prog_steps_o), .dmem_clr_o(dmem_clr_o), .sl_wr_o(sl_wr_o));

/* tb_dcc_core_ctrl.sv */
// Self-checking testbench for the DSP core control block
`timescale 1ns/100ps
module tb_dcc_core_ctrl;
  import dcc_pkg::*;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0, sample_end_i = 1'b0, slew_mute_done_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic so3, so4, tz, cr, mz, iz;
  logic [11:0] steps;
  logic [DMEM_AW-1:0] core_addr_i = '0, dmem_addr_o;
  dcc_dmem_clr_t dmem_clr_o;
  dcc_sl_wr_t sl_wr_o;
  int mismatches = 0, compares = 0, cycles = 0;
  dcc_core_ctrl u_dcc_core_ctrl (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sample_end_i(sample_end_i),
    .slew_mute_done_i(slew_mute_done_i), .serial_out_third_en_o(so3),
    .serial_out_fourth_en_o(so4), .target_zero_o(tz), .clear_regs_o(cr),
    .mult_zero_o(mz), .input_zero_o(iz), .prog_steps_o(steps),
    .dmem_clr_o(dmem_clr_o), .core_addr_i(core_addr_i),
    .dmem_addr_o(dmem_addr_o), .sl_wr_o(sl_wr_o));
  always #5 ref_clk_i = ~ref_clk_i;
  // Longest test is the full memory clear, about 20500 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic tick();
    @(negedge ref_clk_i);
    sample_end_i = 1'b1;
    @(negedge ref_clk_i);
    sample_end_i = 1'b0;
  endtask : tick
  task automatic t_reset();
    rd(CORE_CTRL_ADDR);
    chk("ctrl", 32'h4000, d);
    rd(MOD_SIZE_ADDR);
    chk("mod_size", 32'h28, d);
    rd(8'h05);
    chk("unmapped", 32'h0, d);
    chk("outs", 4'he, {so3, so4, cr, mz});
    chk("steps", 32'ha00, steps);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modulo();
    wr(MOD_SIZE_ADDR, 32'h1);
    core_addr_i = 15'h01ff;
    tick();
    tick();
    repeat (2) @(negedge ref_clk_i);
    chk("mod_wrap", 32'h1, dmem_addr_o);
    core_addr_i = 15'h0200;
    repeat (2) @(negedge ref_clk_i);
    chk("non_mod", 32'h200, dmem_addr_o);
    $display("test modulo done");
  endtask : t_modulo
  task automatic t_ctrl();
    // Last value uses the reserved code 11, which must fall back to full
    logic [15:0] v [4] = '{16'h1341, 16'h4202, 16'h4000, 16'h4203};
    logic [11:0] s [4] = '{12'h500, 12'h280, 12'ha00, 12'ha00};
    for (int i = 0; i < 4; i++) begin
      // Short programs assume digital inputs and outputs only
      wr(CORE_CTRL_ADDR, {16'h0, v[i]});
      chk("steps", s[i], steps);
      chk("so_en", {2{v[i][14]}}, {so3, so4});
      chk("tz", v[i][12], tz);
      chk("clr", !v[i][9], cr);
      chk("mz_iz", {v[i][8], v[i][6]}, {mz, iz});
    end
    $display("test control done");
  endtask : t_ctrl
  task automatic t_slew();
    @(negedge ref_clk_i);
    slew_mute_done_i = 1'b1;
    @(negedge ref_clk_i);
    slew_mute_done_i = 1'b0;
    reg_addr_i = CORE_CTRL_ADDR;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    chk("muted", 1'b1, reg_rdata_o[BIT_SLEW_MUTED]);
    rd(CORE_CTRL_ADDR);
    chk("muted_clr", 1'b0, d[BIT_SLEW_MUTED]);
    $display("test slew flag done");
  endtask : t_slew
  task automatic t_dmem();
    int n = 0;
    logic [DMEM_AW-1:0] first = '1, last = '0;
    wr(CORE_CTRL_ADDR, 32'h4280);
    // First zeroing write is already up when the write task returns
    repeat (20490) begin
      if (dmem_clr_o.we === 1'b1) begin
        if (n == 0) first = dmem_clr_o.addr;
        last = dmem_clr_o.addr;
        n++;
      end
      @(negedge ref_clk_i);
    end
    chk("init_n", DMEM_WORDS, n);
    chk("init_ends", {15'h0000, 15'h4fff}, {first, last});
    rd(CORE_CTRL_ADDR);
    chk("init_bit", 1'b0, d[BIT_DMEM_INIT]);
    $display("test memory init done");
  endtask : t_dmem
  // Count copies after one sample boundary; return last seen write
  task automatic sl_run(logic [31:0] go, output int n, output dcc_sl_wr_t w);
    n = 0;
    wr(CORE_CTRL_ADDR, go);
    repeat (2) @(negedge ref_clk_i);
    tick();
    repeat (8) begin
      @(negedge ref_clk_i);
      if (sl_wr_o.we === 1'b1) begin
        if (n == 0) chk("first_addr", 16'h0, sl_wr_o.addr);
        w = sl_wr_o;
        n++;
      end
    end
    rd(CORE_CTRL_ADDR);
    chk("go_clr", 2'b00, d[5:4]);
  endtask : sl_run
  task automatic t_safeload();
    int n;
    dcc_sl_wr_t w;
    wr(SL_ADDR_BASE, 32'h0);
    wr(SL_DATA_BASE + 8'h3, 32'h12345678);
    sl_run(32'h4220, n, w);
    chk("tgt_n", 32'h2, n);
    chk("tgt_w", 32'h12345678, w.data);
    chk("tgt_p", 1'b0, w.to_param);
    wr(SL_ADDR_BASE, 32'h0);
    sl_run(32'h4210, n, w);
    chk("par_n", 32'h1, n);
    chk("par_w", 1'b1, w.to_param);
    $display("test safeload done");
  endtask : t_safeload
  initial begin
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_modulo();
    t_ctrl();
    t_slew();
    t_dmem();
    t_safeload();
    test_done();
  end
endmodule : tb_dcc_core_ctrl
